/* rtl/dpmm_manager.sv */
// Power-mode state machine with standby timer for a disk drive.
// Assumes commands arrive as one-cycle strobes from same-clock logic;
// reset requests and straps come from pins and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module dpmm_manager
    import dpmm_pkg::*;
#(
    parameter int TICK_MS = TICK_MS_DEFAULT,
    parameter int SPINUP_CYC = 64
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic por_pulse,
    input wire logic if_reset,
    input wire logic puis_enable,
    input wire logic cmd_valid,
    input wire dpmm_cmd_t cmd_code,
    input wire logic [7:0] cmd_count,
    input wire logic cmd_busy,
    input wire logic bg_media,
    input wire logic media_req,
    input wire dpmm_sub_t idle_sub,
    output logic cmd_done,
    output logic [7:0] mode_report,
    output logic media_go,
    output logic status_busy,
    output logic status_ready,
    output logic iface_active,
    output logic heads_loaded,
    output logic spindle_full,
    output logic spindle_reduced,
    output logic spindle_on,
    output logic servo_full,
    output logic aux_power,
    output logic timer_enabled,
    output dpmm_state_t power_state
);
    // Ticks are counted in clock cycles; a step may exceed 4096 cycles
    localparam longint TICK_CYC_L = (longint'(CLK_HZ) / 1000) * longint'(TICK_MS);
    localparam logic [31:0] TICK_CYC = (TICK_CYC_L < 1) ? 32'h0000_0001 : 32'(TICK_CYC_L);
    localparam logic [15:0] SPIN_CYC = 16'(SPINUP_CYC);

    logic ifr_s1_r, ifr_s2_r, ifr_s3_r;
    logic puis_s1_r, puis_s2_r;
    logic por_s1_r, por_s2_r;
    logic por_seen_r;
    dpmm_state_t state_r, state_nxt;
    logic [7:0] count_r, count_nxt;
    logic timer_en_r, timer_en_nxt;
    logic [31:0] tick_r;
    logic [7:0] steps_r;
    logic [15:0] spin_r;
    logic done_r;
    logic [7:0] report_r;
    logic iface_r, loaded_r, spin_on_r, reduced_r;
    logic full_r, servo_r, aux_r;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ifr_s1_r <= 1'b0;
            ifr_s2_r <= 1'b0;
            ifr_s3_r <= 1'b0;
        end else begin
            ifr_s1_r <= if_reset;
            ifr_s2_r <= ifr_s1_r;
            ifr_s3_r <= ifr_s2_r;
        end
    end

    // Strap keeps sampling through reset, so power-on sees its settled level
    always_ff @(posedge clk_sys) begin
        puis_s1_r <= puis_enable;
        puis_s2_r <= puis_s1_r;
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            por_s1_r <= 1'b0;
            por_s2_r <= 1'b0;
        end else begin
            por_s1_r <= por_pulse;
            por_s2_r <= por_s1_r;
        end
    end

    // One view per state keeps the decodes below readable
    wire st_active = (state_r == DPMM_ACTIVE);
    wire st_idle = (state_r == DPMM_IDLE);
    wire st_standby = (state_r == DPMM_STANDBY);
    wire st_spinup = (state_r == DPMM_SPINUP);
    wire st_pend = (state_r == DPMM_SLEEP_PEND);
    wire st_sleep = (state_r == DPMM_SLEEP);

    wire ifr_rise = ifr_s2_r & ~ifr_s3_r;
    wire por_now = por_s2_r | ~por_seen_r;
    wire cmd_any = cmd_valid;
    wire is_idle_cmd = cmd_valid & ((cmd_code == DPMM_CMD_IDLE) | (cmd_code == DPMM_CMD_IDLE_IMM));
    wire is_stby_cmd = cmd_valid & ((cmd_code == DPMM_CMD_STANDBY) | (cmd_code == DPMM_CMD_STANDBY_IMM));
    wire loads_timer = cmd_valid & ((cmd_code == DPMM_CMD_IDLE) | (cmd_code == DPMM_CMD_STANDBY));
    wire is_sleep_cmd = cmd_valid & (cmd_code == DPMM_CMD_SLEEP);
    wire is_check_cmd = cmd_valid & (cmd_code == DPMM_CMD_CHECK);
    wire working = cmd_busy | bg_media;
    wire awake = st_active | st_idle;
    wire tick_hit = (tick_r == TICK_CYC - 32'h0000_0001);
    // A command in the expiry cycle wins, since it restarts the period
    wire expired = timer_en_r & awake & tick_hit & ~cmd_any & (steps_r + 8'h01 >= count_r);
    wire tick_clear = cmd_any | working | ~awake | ~timer_en_r;
    wire spun_up = (spin_r == SPIN_CYC - 16'h0001);
    wire in_sleep = st_pend | st_sleep;

    // Timer setting: non-immediate idle/standby load it, power-on clears it
    always_comb begin
        count_nxt = count_r;
        timer_en_nxt = timer_en_r;
        if (por_now) begin
            count_nxt = CNT_RESET;
            timer_en_nxt = 1'b0;
        end else if (loads_timer & ~in_sleep) begin
            count_nxt = cmd_count;
            timer_en_nxt = (cmd_count != CNT_OFF);
        end
    end

    // Next power state; power-on strap and resets take priority
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            DPMM_ACTIVE, DPMM_IDLE: begin
                if (is_sleep_cmd) begin
                    state_nxt = DPMM_SLEEP_PEND;
                end else if (is_stby_cmd | expired) begin
                    state_nxt = DPMM_STANDBY;
                end else if (is_idle_cmd) begin
                    state_nxt = DPMM_IDLE;
                end else if (working) begin
                    state_nxt = DPMM_ACTIVE;
                end else begin
                    state_nxt = DPMM_IDLE;
                end
            end
            DPMM_STANDBY: begin
                if (is_sleep_cmd) begin
                    state_nxt = DPMM_SLEEP_PEND;
                end else if (is_idle_cmd) begin
                    state_nxt = DPMM_IDLE;
                end else if (is_stby_cmd) begin
                    state_nxt = DPMM_STANDBY;
                end else if (media_req) begin
                    state_nxt = DPMM_SPINUP;
                end
            end
            DPMM_SPINUP: begin
                if (is_sleep_cmd) begin
                    state_nxt = DPMM_SLEEP_PEND;
                end else if (is_stby_cmd) begin
                    state_nxt = DPMM_STANDBY;
                end else if (is_idle_cmd) begin
                    state_nxt = DPMM_IDLE;
                end else if (spun_up) begin
                    state_nxt = DPMM_ACTIVE;
                end
            end
            DPMM_SLEEP_PEND: begin
                state_nxt = DPMM_SLEEP;
            end
            DPMM_SLEEP: begin
                state_nxt = DPMM_SLEEP;
            end
            default: begin
                state_nxt = DPMM_IDLE;
            end
        endcase
        if (ifr_rise & in_sleep) begin
            state_nxt = DPMM_STANDBY;
        end
        if (por_now) begin
            state_nxt = puis_s2_r ? DPMM_STANDBY : DPMM_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_r <= DPMM_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Interface reset leaves timer setting alone; only power-on clears it
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            count_r <= CNT_RESET;
            timer_en_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            timer_en_r <= timer_en_nxt;
        end
    end

    // First cycle out of reset is treated as a power-on event
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            por_seen_r <= 1'b0;
        end else begin
            por_seen_r <= 1'b1;
        end
    end

    // Any command or activity restarts the inactivity period
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            tick_r <= 32'h0000_0000;
        end else if (tick_clear | tick_hit) begin
            tick_r <= 32'h0000_0000;
        end else begin
            tick_r <= tick_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            steps_r <= 8'h00;
        end else if (tick_clear) begin
            steps_r <= 8'h00;
        end else if (tick_hit) begin
            steps_r <= steps_r + 8'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            spin_r <= 16'h0000;
        end else if (state_r == DPMM_SPINUP) begin
            spin_r <= spin_r + 16'h0001;
        end else begin
            spin_r <= 16'h0000;
        end
    end

    wire [7:0] report_val = st_spinup ? RPT_SPINUP :
                            st_standby ? RPT_STANDBY :
                            st_idle ? RPT_IDLE : RPT_ACTIVE;

    // Drive controls are registered from the next state so they never glitch
    wire dpmm_sub_t sub = idle_sub;
    wire nxt_active = (state_nxt == DPMM_ACTIVE);
    wire nxt_idle = (state_nxt == DPMM_IDLE);
    wire nxt_awake = nxt_active | nxt_idle;
    wire nxt_spinup = (state_nxt == DPMM_SPINUP);
    wire nxt_loaded = nxt_active | (nxt_idle & (sub == DPMM_SUB_ACTIVE_IDLE));
    wire nxt_reduced = nxt_idle & (sub == DPMM_SUB_LOW_RPM);

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            iface_r <= 1'b1;
            loaded_r <= 1'b1;
            spin_on_r <= 1'b1;
            reduced_r <= 1'b0;
            full_r <= 1'b1;
            servo_r <= 1'b0;
            aux_r <= 1'b1;
        end else begin
            iface_r <= (state_nxt != DPMM_SLEEP);
            loaded_r <= nxt_loaded;
            spin_on_r <= nxt_awake | nxt_spinup;
            reduced_r <= nxt_reduced;
            full_r <= nxt_awake & ~nxt_reduced;
            servo_r <= nxt_active;
            aux_r <= nxt_loaded;
        end
    end

    // Every command completes in one cycle, sleep included, before sleep locks out
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            done_r <= 1'b0;
        end else begin
            done_r <= cmd_valid & ~st_sleep;
        end
    end

    // Report holds until the next query so the host may read it late
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            report_r <= RPT_IDLE;
        end else if (is_check_cmd) begin
            report_r <= report_val;
        end
    end

    assign cmd_done = done_r;
    assign mode_report = report_r;
    assign power_state = state_r;
    assign timer_enabled = timer_en_r;
    assign media_go = media_req & awake;
    assign status_busy = st_active & cmd_busy;
    // Ready is an interface flag only; standby still reports ready
    assign status_ready = ~in_sleep;
    assign iface_active = iface_r;
    assign heads_loaded = loaded_r;
    assign spindle_on = spin_on_r;
    assign spindle_reduced = reduced_r;
    assign spindle_full = full_r;
    assign servo_full = servo_r;
    assign aux_power = aux_r;
endmodule
`default_nettype wire

/* rtl/dpmm_pkg.sv */
// Constants and types for the drive power-mode manager.
// Assumes a single 20 MHz core clock and a command decoder upstream.
package dpmm_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int TICK_MS_DEFAULT = 5_000;
    localparam logic [7:0] CNT_OFF = 8'h00;
    localparam logic [7:0] CNT_RESET = 8'h00;

    typedef enum logic [2:0] {
        DPMM_ACTIVE = 3'b000,
        DPMM_IDLE = 3'b001,
        DPMM_STANDBY = 3'b010,
        DPMM_SPINUP = 3'b011,
        DPMM_SLEEP_PEND = 3'b100,
        DPMM_SLEEP = 3'b101
    } dpmm_state_t;

    typedef enum logic [1:0] {
        DPMM_SUB_ACTIVE_IDLE = 2'b00,
        DPMM_SUB_LOW_POWER = 2'b01,
        DPMM_SUB_LOW_RPM = 2'b10
    } dpmm_sub_t;

    typedef enum logic [2:0] {
        DPMM_CMD_IDLE = 3'b000,
        DPMM_CMD_IDLE_IMM = 3'b001,
        DPMM_CMD_STANDBY = 3'b010,
        DPMM_CMD_STANDBY_IMM = 3'b011,
        DPMM_CMD_SLEEP = 3'b100,
        DPMM_CMD_CHECK = 3'b101,
        DPMM_CMD_OTHER = 3'b110
    } dpmm_cmd_t;

    // Power-mode report codes for the query answer
    localparam logic [7:0] RPT_STANDBY = 8'h00;
    localparam logic [7:0] RPT_SPINUP = 8'h40;
    localparam logic [7:0] RPT_IDLE = 8'h80;
    localparam logic [7:0] RPT_ACTIVE = 8'hFF;
endpackage

/* verif/dpmm_manager_assertions.sv */
// Port-level checks for the power-mode manager.
// Assumes the bind below and the single clk_sys domain.
`timescale 1ns/1ps
`default_nettype none
module dpmm_manager_checker
    import dpmm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic if_reset,
    input wire logic cmd_valid,
    input wire dpmm_cmd_t cmd_code,
    input wire logic [7:0] cmd_count,
    input wire logic cmd_busy,
    input wire logic bg_media,
    input wire logic media_req,
    input wire dpmm_sub_t idle_sub,
    input wire logic cmd_done,
    input wire logic media_go,
    input wire logic status_busy,
    input wire logic status_ready,
    input wire logic iface_active,
    input wire logic heads_loaded,
    input wire logic spindle_reduced,
    input wire logic timer_enabled,
    input wire dpmm_state_t power_state
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Spin-up is left out of steady; a command there is still answered the next cycle
    wire steady = power_state inside {DPMM_ACTIVE, DPMM_IDLE, DPMM_STANDBY};
    wire quiet = !cmd_busy && !bg_media && !media_req;
    wire go_exp = media_req && power_state inside {DPMM_ACTIVE, DPMM_IDLE};
    done_after_cmd_a: assert property (cmd_valid && steady |=> cmd_done)
        else $error("command not completed");
    sleep_refuse_a: assert property (cmd_valid && power_state == DPMM_SLEEP |=> !cmd_done)
        else $error("command answered in sleep");
    idle_cmd_a: assert property (cmd_valid && cmd_code inside {DPMM_CMD_IDLE, DPMM_CMD_IDLE_IMM} && steady && quiet
        |=> power_state == DPMM_IDLE) else $error("idle command missed");
    standby_cmd_a: assert property (cmd_valid && cmd_code inside {DPMM_CMD_STANDBY, DPMM_CMD_STANDBY_IMM} && steady
        && quiet |=> power_state == DPMM_STANDBY) else $error("standby command missed");
    sleep_order_a: assert property (cmd_valid && cmd_code == DPMM_CMD_SLEEP && steady
        |=> cmd_done && iface_active ##1 power_state == DPMM_SLEEP && !iface_active) else $error("sleep order");
    timer_load_a: assert property (cmd_valid && cmd_code inside {DPMM_CMD_IDLE, DPMM_CMD_STANDBY} && steady
        |=> timer_enabled == ($past(cmd_count) != CNT_OFF)) else $error("timer load wrong");
    ready_flags_a: assert property (power_state inside {DPMM_IDLE, DPMM_STANDBY}
        |-> !status_busy && status_ready && iface_active) else $error("idle or standby flags wrong");
    media_gate_a: assert property (media_go == go_exp) else $error("media grant wrong");
    low_rpm_a: assert property (power_state == DPMM_IDLE && idle_sub == DPMM_SUB_LOW_RPM && $stable(idle_sub)
        |-> !heads_loaded && spindle_reduced) else $error("reduced speed idle wrong");
    sleep_wake_a: assert property ($rose(if_reset) && power_state == DPMM_SLEEP
        |-> ##[1:8] power_state == DPMM_STANDBY) else $error("no wake to standby");
endmodule
bind dpmm_manager dpmm_manager_checker u_chk (.*);
`default_nettype wire

/* verif/dpmm_host_model.sv */
// Host controller model: issues power commands as one-cycle strobes.
// Assumes the bench calls send from a single process.
`timescale 1ns/1ps
`default_nettype none
module dpmm_host_model
    import dpmm_pkg::*;
(
    input wire logic clk_sys,
    output logic cmd_valid,
    output dpmm_cmd_t cmd_code,
    output logic [7:0] cmd_count
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code = DPMM_CMD_OTHER;
        cmd_count = 8'h00;
    end
    // Count is inverted once the strobe drops, so a stale value is never trusted
    task automatic send(input dpmm_cmd_t code, input logic [7:0] count);
        @(posedge clk_sys) #2;
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_count = count;
        @(posedge clk_sys) #2;
        cmd_valid = 1'b0;
        cmd_count = ~count;
    endtask
endmodule
`default_nettype wire

/* verif/tb_drive_power_mode_manager.sv */
// Self-checking bench for the power-mode manager.
// Assumes the host model drives commands and the bench all other inputs.
`timescale 1ns/1ps
`default_nettype none
module tb_drive_power_mode_manager;
    import dpmm_pkg::*;
    logic clk_sys = 1'b0, reset_n = 1'b0, por_pulse = 1'b0, if_reset = 1'b0, puis_enable = 1'b0;
    logic cmd_busy = 1'b0, bg_media = 1'b0, media_req = 1'b0, cmd_valid, cmd_done, media_go;
    logic status_busy, status_ready, iface_active, heads_loaded, spindle_full, spindle_reduced, timer_enabled;
    logic spindle_on, servo_full, aux_power;
    logic [7:0] cmd_count, mode_report;
    dpmm_cmd_t cmd_code;
    dpmm_sub_t idle_sub = DPMM_SUB_ACTIVE_IDLE;
    dpmm_state_t power_state;
    int fails = 0, compares = 0;
    always #25 clk_sys = ~clk_sys;
    dpmm_host_model host (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_count(cmd_count));
    dpmm_manager #(.TICK_MS(0), .SPINUP_CYC(4)) DUT (.*);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_st(input dpmm_state_t s);
        for (int i = 0; i < 40 && power_state !== s; i++) @(posedge clk_sys) #2;
        chk(8'(power_state), 8'(s));
    endtask
    task automatic end_of_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic t_reset(input logic strap, input dpmm_state_t s);
        puis_enable = strap;
        reset_n = 1'b0;
        repeat (5) @(posedge clk_sys);
        #2 reset_n = 1'b1;
        @(posedge clk_sys) #2;
        wait_st(s);
        chk(8'(timer_enabled), 8'h00);
    endtask
    task automatic t_cmds;
        host.send(DPMM_CMD_STANDBY_IMM, 8'h00);
        chk(8'(power_state), 8'(DPMM_STANDBY));
        chk(8'({status_busy, status_ready}), 8'h01);
        host.send(DPMM_CMD_CHECK, 8'h00);
        chk(mode_report, RPT_STANDBY);
        host.send(DPMM_CMD_IDLE, 8'h00);
        chk(8'(power_state), 8'(DPMM_IDLE));
        chk(8'(timer_enabled), 8'h00);
        host.send(DPMM_CMD_CHECK, 8'h00);
        chk(mode_report, RPT_IDLE);
        host.send(DPMM_CMD_IDLE_IMM, 8'h00);
        chk(8'(cmd_done), 8'h01);
    endtask
    task automatic t_sub;
        dpmm_sub_t subs[3] = '{DPMM_SUB_ACTIVE_IDLE, DPMM_SUB_LOW_POWER, DPMM_SUB_LOW_RPM};
        logic [5:0] exp[3] = '{6'h2B, 6'h09, 6'h11};
        for (int i = 0; i < 3; i++) begin
            idle_sub = subs[i];
            repeat (2) @(posedge clk_sys) #2;
            chk(8'({heads_loaded, spindle_reduced, spindle_full, servo_full, aux_power, spindle_on}), 8'(exp[i]));
        end
    endtask
    task automatic t_busy;
        cmd_busy = 1'b1;
        wait_st(DPMM_ACTIVE);
        cmd_busy = 1'b0;
        wait_st(DPMM_IDLE);
        bg_media = 1'b1;
        wait_st(DPMM_ACTIVE);
        bg_media = 1'b0;
        wait_st(DPMM_IDLE);
    endtask
    task automatic t_media;
        media_req = 1'b1;
        #1 chk(8'(media_go), 8'h01);
        media_req = 1'b0;
        host.send(DPMM_CMD_STANDBY_IMM, 8'h00);
        media_req = 1'b1;
        #1 chk(8'(media_go), 8'h00);
        wait_st(DPMM_ACTIVE);
        media_req = 1'b0;
        wait_st(DPMM_IDLE);
    endtask
    task automatic t_timer;
        host.send(DPMM_CMD_IDLE, 8'h02);
        chk(8'(timer_enabled), 8'h01);
        wait_st(DPMM_STANDBY);
    endtask
    task automatic t_sleep;
        host.send(DPMM_CMD_STANDBY, 8'h05);
        chk(8'(timer_enabled), 8'h01);
        host.send(DPMM_CMD_SLEEP, 8'h00);
        chk(8'({cmd_done, iface_active}), 8'h03);
        @(posedge clk_sys) #2;
        chk(8'({power_state, iface_active}), 8'({DPMM_SLEEP, 1'b0}));
        host.send(DPMM_CMD_IDLE, 8'h00);
        chk(8'({power_state, cmd_done}), 8'({DPMM_SLEEP, 1'b0}));
        if_reset = 1'b1;
        wait_st(DPMM_STANDBY);
        if_reset = 1'b0;
        chk(8'(timer_enabled), 8'h01);
        repeat (4) @(posedge clk_sys) #2;
        if_reset = 1'b1;
        repeat (6) @(posedge clk_sys) #2;
        chk(8'(power_state), 8'(DPMM_STANDBY));
        if_reset = 1'b0;
    endtask
    initial begin
        t_reset(1'b1, DPMM_STANDBY);
        t_reset(1'b0, DPMM_IDLE);
        t_cmds;
        t_sub;
        t_busy;
        t_media;
        t_timer;
        t_sleep;
        end_of_test;
    end
    // Whole run is well under two hundred cycles; the 2000-cycle limit leaves ample margin
    initial begin
        #100000;
        fails++;
        end_of_test;
    end
endmodule
`default_nettype wire
